// ==== pwdb_bridge_model.sv ====
/* Half-bridge leg and ADC sequencer on the generator 0 pins.
   Assumes active-high pins with no inversion while tallied. */
`timescale 1ns/1ns
module pwdb_bridge_model (
    // Pins in, tallies out.
    input wire logic       sys_clk,
    input wire logic [3:0] pwmPin,
    input wire logic [1:0] adcTrig,
    output int             shootCnt = 0,
    output int             trigCnt = 0
);
    always @(posedge sys_clk) begin
        shootCnt <= shootCnt + int'(pwmPin[0] && pwmPin[1]);
        trigCnt <= trigCnt + int'(adcTrig[0]);
    end
endmodule : pwdb_bridge_model

// ==== pwdb_pkg.sv ====
/*
 * Constants and carrier types for the PWM dead-band and output block.
 * Assumes a 32-bit AXI4-Lite register port with 12-bit byte addresses.
 */
package pwdb_pkg;

    localparam int NUM_GEN = 2;
    localparam int NUM_OUT = 4;
    localparam int CNT_W   = 16;
    localparam int DB_W    = 12;
    localparam int NUM_EV  = 4;

    // ************************************************************
    // Register offsets.
    // ************************************************************
    localparam logic [11:0] OFF_CTL     = 12'h000;
    localparam logic [11:0] OFF_SYNC    = 12'h004;
    localparam logic [11:0] OFF_ENABLE  = 12'h008;
    localparam logic [11:0] OFF_INVERT  = 12'h00C;
    localparam logic [11:0] OFF_FAULT   = 12'h010;
    localparam logic [11:0] OFF_INTEN   = 12'h014;
    localparam logic [11:0] OFF_RIS     = 12'h018;
    localparam logic [11:0] OFF_ISC     = 12'h01C;
    localparam logic [11:0] OFF_STATUS  = 12'h020;
    localparam logic [11:0] OFF_GEN0    = 12'h040;
    localparam logic [5:0]  G_CTL       = 6'h00;
    localparam logic [5:0]  G_INTEN     = 6'h04;
    localparam logic [5:0]  G_RIS       = 6'h08;
    localparam logic [5:0]  G_ISC       = 6'h0C;
    localparam logic [5:0]  G_LOAD      = 6'h10;
    localparam logic [5:0]  G_COUNT     = 6'h14;
    localparam logic [5:0]  G_CMPA      = 6'h18;
    localparam logic [5:0]  G_CMPB      = 6'h1C;
    localparam logic [5:0]  G_DBCTL     = 6'h28;
    localparam logic [5:0]  G_DBRISE    = 6'h2C;
    localparam logic [5:0]  G_DBFALL    = 6'h30;

    // ************************************************************
    // Field positions and reset values.
    // ************************************************************
    localparam int GCTL_RUN      = 0;
    localparam int GCTL_DBGRUN   = 1;
    localparam int GCTL_LOADSYNC = 2;
    localparam int GCTL_CMPSYNC  = 3;
    localparam int EV_ZERO       = 0;
    localparam int EV_LOAD       = 1;
    localparam int EV_CMPA       = 2;
    localparam int EV_CMPB       = 3;
    localparam int TRIG_POS      = 8;
    localparam int FAULT_POS     = 16;
    localparam logic [31:0] RESET_VAL = 32'h0000_0000;
    localparam logic [1:0]  RESP_OKAY   = 2'h0;
    localparam logic [1:0]  RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic [3:0]       ctl;
        logic [3:0]       intSel;
        logic [3:0]       trigSel;
        logic [3:0]       ris;
        logic [CNT_W-1:0] loadShadow;
        logic [CNT_W-1:0] cmpAShadow;
        logic [CNT_W-1:0] cmpBShadow;
        logic             loadPend;
        logic             cmpPend;
        logic [CNT_W-1:0] periodValue;
        logic [CNT_W-1:0] compareFirst;
        logic [CNT_W-1:0] compareSecond;
        logic [CNT_W-1:0] count;
        logic             dbEn;
        logic [DB_W-1:0]  dbRise;
        logic [DB_W-1:0]  dbFall;
        logic [DB_W-1:0]  riseCnt;
        logic [DB_W-1:0]  fallCnt;
        logic             prevRaw;
        logic             dbFirst;
        logic             dbSecond;
        logic             adcTrig;
    } pwdb_gen_t;

endpackage : pwdb_pkg

// ==== pwdb_props.sv ====
/* Port checker bound to pwdb_top.
   Assumes clkEn stays high while the rules are judged. */
`timescale 1ns/1ns
module pwdb_props (
    // Watched ports.
    input wire logic       sys_clk, rst_n, clkEn, faultIn, dbgHalt, faultIntr, s_axi_bready,
    input wire logic       s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid,
    input wire logic [1:0] s_axi_bresp, evZero, evLoad, evCmpFirst, evCmpSecond, genIntr, adcTrig
);
    // ****
    // Checks.
    // ****
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n || !clkEn);
    wire logic [1:0] ev = evZero | evLoad | evCmpFirst | evCmpSecond;
    a_zero_load: assert property (evZero[0] && !dbgHalt |=> evLoad[0])
        else $error("no load pulse");
    a_cmp_masked: assert property ((evZero[0] || evLoad[0]) |-> !evCmpFirst[0])
        else $error("compare beside zero");
    a_trig_cause: assert property ((adcTrig & ~$past(ev)) == 2'b00)
        else $error("stray trigger");
    a_intr_cause: assert property ($rose(genIntr[0]) |-> $past(ev[0] || s_axi_wvalid))
        else $error("stray interrupt");
    a_fault_cause: assert property ($rose(faultIntr) |-> $past(faultIn || s_axi_wvalid))
        else $error("stray fault interrupt");
    a_resp_time: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |-> ##2 s_axi_bvalid) else $error("late response");
    a_resp_refuse: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("taken in response");
    a_resp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
        && $stable(s_axi_bresp)) else $error("response dropped");
    c_trig: cover property (adcTrig[0]);
    c_fault: cover property (faultIntr);
    c_intr: cover property ($rose(genIntr[0]));
endmodule : pwdb_props
bind pwdb_top pwdb_props i_props (.*);

// ==== pwdb_tb_top.sv ====
/* Directed bench for pwdb_top through AXI4-Lite calls.
   Assumes package, design, checker and bridge model compile first. */
`timescale 1ns/1ns
module pwdb_tb_top;
    // ****
    // Stimulus and tests.
    // ****
    logic        sys_clk = 0, rst_n = 0, clkEn = 1, faultIn = 0, dbgHalt = 0, faultIntr;
    logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
    logic        s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic        s_axi_rvalid;
    logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
    logic [31:0] s_axi_wdata = 0, s_axi_rdata;
    logic [1:0]  genFirstRawOut = 0, genSecondRawOut = 0, s_axi_bresp, s_axi_rresp;
    logic [1:0]  evZero, genIntr, adcTrig;
    logic [3:0]  pwmPin;
    int          error_cnt = 0, samples_checked = 0, shootCnt, trigCnt, n, t0;
    pwdb_top i_dut (.*, .s_axi_wstrb(4'hF), .evLoad(), .evCmpFirst(), .evCmpSecond());
    pwdb_bridge_model i_model (.sys_clk, .pwmPin, .adcTrig, .shootCnt, .trigCnt);
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch at %0t: got %h, want %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        s_axi_awaddr <= a; s_axi_wdata <= d;
        s_axi_awvalid <= 1; s_axi_wvalid <= 1;
        do begin
            @(posedge sys_clk);
            if (s_axi_awready) s_axi_awvalid <= 0;
            if (s_axi_wready) s_axi_wvalid <= 0;
        end while ((s_axi_awvalid && !s_axi_awready) || (s_axi_wvalid && !s_axi_wready));
        do @(posedge sys_clk); while (!s_axi_bvalid);
        s_axi_bready <= 1;
        do @(posedge sys_clk); while (!s_axi_bvalid);
        s_axi_bready <= 0;
    endtask : wr
    task automatic rdc(input logic [11:0] a, input logic [31:0] m, d, input logic [1:0] r);
        s_axi_araddr <= a; s_axi_arvalid <= 1;
        do @(posedge sys_clk); while (!s_axi_arready);
        s_axi_arvalid <= 0; s_axi_rready <= 1;
        do @(posedge sys_clk); while (!s_axi_rvalid);
        s_axi_rready <= 0;
        chk(s_axi_rdata & m, d);
        chk({30'h0, s_axi_rresp}, {30'h0, r});
    endtask : rdc
    task automatic pins(input logic [3:0] e);
        repeat (4) @(posedge sys_clk);
        chk({28'h0, pwmPin}, {28'h0, e});
    endtask : pins
    task automatic period(output int p);
        p = 0;
        do @(posedge sys_clk); while (!evZero[0]);
        do begin @(posedge sys_clk); p++; end while (!evZero[0]);
    endtask : period
    task automatic low_span(output int c);
        c = 0;
        repeat (30) begin @(posedge sys_clk); c += int'(pwmPin[1:0] === 2'b00); end
    endtask : low_span
    task automatic stop_test;
        $display("errors %0d checks %0d", error_cnt, samples_checked);
        if (error_cnt == 0 && samples_checked > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : stop_test
    initial forever #4 sys_clk = ~sys_clk;
    initial begin
        repeat (20000) @(posedge sys_clk);
        error_cnt++;
        stop_test();
    end
    initial begin
        repeat (20) @(posedge sys_clk);
        rst_n <= 1;
        @(posedge sys_clk);
        rdc(12'h008, 32'hFFFF_FFFF, 32'h0, 2'h0);
        rdc(12'hFFC, 32'hFFFF_FFFF, 32'h0, pwdb_pkg::RESP_SLVERR);
        genFirstRawOut <= 2'b01; genSecondRawOut <= 2'b01;
        wr(12'h008, 32'hF); pins(4'b0011);
        wr(12'h00C, 32'h1); pins(4'b0010);
        wr(12'h00C, 32'h0); wr(12'h008, 32'h1); pins(4'b0001);
        wr(12'h008, 32'h3); wr(12'h010, 32'h2); wr(12'h014, 32'h0001_0000);
        faultIn <= 1; pins(4'b0001);
        chk({31'h0, faultIntr}, 32'h1);
        faultIn <= 0; genFirstRawOut <= 2'b00; genSecondRawOut <= 2'b00;
        wr(12'h010, 32'h0); wr(12'h068, 32'h1); wr(12'h06C, 32'h5); wr(12'h070, 32'h3);
        pins(4'b0010);
        t0 = shootCnt;
        genFirstRawOut <= 2'b01; low_span(n); chk(n, 5);
        chk({28'h0, pwmPin}, 32'h1);
        genFirstRawOut <= 2'b00; low_span(n); chk(n, 3);
        chk({28'h0, pwmPin}, 32'h2);
        chk(shootCnt - t0, 0);
        wr(12'h068, 32'h0); wr(12'h050, 32'h9); wr(12'h044, 32'h0101); wr(12'h040, 32'h1);
        period(n); chk(n, 10);
        t0 = trigCnt; period(n); chk(trigCnt - t0, 2);
        chk({30'h0, genIntr}, 32'h1);
        rdc(12'h048, 32'h1, 32'h1, 2'h0);
        wr(12'h050, 32'h4); period(n); chk(n, 5);
        wr(12'h040, 32'h5); wr(12'h050, 32'h7); period(n); period(n); chk(n, 5);
        wr(12'h000, 32'h1); period(n); period(n); chk(n, 8);
        rdc(12'h000, 32'h3, 32'h0, 2'h0);
        wr(12'h004, 32'h3); rdc(12'h004, 32'h3, 32'h0, 2'h0);
        dbgHalt <= 1; repeat (20) @(posedge sys_clk);
        rdc(12'h054, 32'hFFFF, 32'h0, 2'h0);
        dbgHalt <= 0;
        stop_test();
    end
endmodule : pwdb_tb_top

// ==== pwdb_top.sv ====
/*
 * PWM back end: counters with shadowed load and compare values, dead-band
 * pairs, event selection for interrupts and ADC triggers, fault and debug
 * stall handling and the pin output stage, behind an AXI4-Lite slave.
 * Assumes the action core outside supplies the raw generator outputs and
 * that fault and debug halt are synchronous to sys_clk.
 */
`timescale 1ns/1ns

// Notes on behaviour
// - Dead-band off passes both raw outputs.
// - Dead-band on uses first raw only.
// - First output delays rising edge only.
// - Second output inverted, rise delayed after fall.
// - Pair never high together with dead-band on.
// - Any event set raises generator interrupt.
// - Separate event set makes ADC trigger.
// - Events come from raw counter, not dead-band.
// - Counter reset clears chosen counters together.
// - Immediate update applies at counter zero.
// - Synchronous update waits for request, then zero.
// - Update mode chosen per load and compare.
// - Fault forces masked outputs inactive.
// - Fault can raise processor interrupt.
// - Debug stall halts at zero or runs.
// - Debug stall never raises interrupt.
// - One register enables all outputs.
// - Inversion applied last per output.
// - Zero and load pulses one cycle each.
// - Counter reset bit self-clears.
// - Update request cleared only by hardware.
module pwdb_top (
    // Clock, reset and enable.
    input  wire logic        sys_clk,
    input  wire logic        rst_n,
    input  wire logic        clkEn,
    // AXI4-Lite slave.
    input  wire logic [11:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [11:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // Raw generator outputs and external conditions.
    input  wire logic [1:0]  genFirstRawOut,
    input  wire logic [1:0]  genSecondRawOut,
    input  wire logic        faultIn,
    input  wire logic        dbgHalt,
    // Counter events to the action core.
    output logic [1:0]       evZero,
    output logic [1:0]       evLoad,
    output logic [1:0]       evCmpFirst,
    output logic [1:0]       evCmpSecond,
    // Pins, interrupts and triggers.
    output logic [3:0]       pwmPin,
    output logic [1:0]       genIntr,
    output logic             faultIntr,
    output logic [1:0]       adcTrig
);

    pwdb_pkg::pwdb_gen_t gen      [pwdb_pkg::NUM_GEN];
    pwdb_pkg::pwdb_gen_t next_gen [pwdb_pkg::NUM_GEN];

    logic [1:0]  updateRequest, next_updateRequest;
    logic [1:0]  counterReset, next_counterReset;
    logic [3:0]  outputEnableMask, next_outputEnableMask;
    logic [3:0]  invertMask, next_invertMask;
    logic [3:0]  faultMask, next_faultMask;
    logic        faultIntEn, next_faultIntEn;
    logic        faultRis, next_faultRis;
    logic [3:0]  pinReg, next_pinReg;

    logic [11:0] awAddr, next_awAddr;
    logic        awHeld, next_awHeld;
    logic [31:0] wData, next_wData;
    logic [3:0]  wStrb, next_wStrb;
    logic        wHeld, next_wHeld;
    logic        bValid, next_bValid;
    logic [1:0]  bResp, next_bResp;
    logic        rValid, next_rValid;
    logic [1:0]  rResp, next_rResp;
    logic [31:0] rData, next_rData;

    logic [1:0]  running;
    logic [3:0]  events [pwdb_pkg::NUM_GEN];
    logic        doWrite;
    logic        doRead;

    // ************************************************************
    // Bus handshakes.
    // ************************************************************
    assign s_axi_awready = clkEn && !awHeld && !bValid;
    assign s_axi_wready  = clkEn && !wHeld && !bValid;
    assign s_axi_arready = clkEn && !rValid;
    assign s_axi_bvalid  = bValid;
    assign s_axi_bresp   = bResp;
    assign s_axi_rvalid  = rValid;
    assign s_axi_rresp   = rResp;
    assign s_axi_rdata   = rData;
    assign doWrite       = awHeld && wHeld && !bValid;
    assign doRead        = s_axi_arvalid && s_axi_arready;

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] dat,
                                          input logic [3:0] strb);
        logic [31:0] m;
        m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
        return (old & ~m) | (dat & m);
    endfunction : merge

    function automatic logic isMapped(input logic [11:0] a);
        logic [5:0] r;
        r = a[5:0];
        if (a[11:8] == 4'h0 && (a[7:6] == 2'h1 || a[7:6] == 2'h2)) begin
            return r == pwdb_pkg::G_CTL || r == pwdb_pkg::G_INTEN || r == pwdb_pkg::G_RIS
                || r == pwdb_pkg::G_ISC || r == pwdb_pkg::G_LOAD || r == pwdb_pkg::G_COUNT
                || r == pwdb_pkg::G_CMPA || r == pwdb_pkg::G_CMPB || r == pwdb_pkg::G_DBCTL
                || r == pwdb_pkg::G_DBRISE || r == pwdb_pkg::G_DBFALL;
        end
        return a[1:0] == 2'h0 && a <= pwdb_pkg::OFF_STATUS;
    endfunction : isMapped

    // ************************************************************
    // Counter events.
    // ************************************************************
    always_comb begin
        for (int g = 0; g < pwdb_pkg::NUM_GEN; g++) begin
            running[g] = gen[g].ctl[pwdb_pkg::GCTL_RUN] && !(dbgHalt
                && !gen[g].ctl[pwdb_pkg::GCTL_DBGRUN] && gen[g].count == '0);
            events[g][pwdb_pkg::EV_ZERO] = running[g] && gen[g].count == '0;
            events[g][pwdb_pkg::EV_LOAD] = running[g] && gen[g].count == gen[g].periodValue;
            events[g][pwdb_pkg::EV_CMPA] = running[g] && gen[g].count == gen[g].compareFirst
                && gen[g].count != '0 && gen[g].count != gen[g].periodValue;
            events[g][pwdb_pkg::EV_CMPB] = running[g] && gen[g].count == gen[g].compareSecond
                && gen[g].count != '0 && gen[g].count != gen[g].periodValue;
            evZero[g]      = events[g][pwdb_pkg::EV_ZERO];
            evLoad[g]      = events[g][pwdb_pkg::EV_LOAD];
            evCmpFirst[g]  = events[g][pwdb_pkg::EV_CMPA];
            evCmpSecond[g] = events[g][pwdb_pkg::EV_CMPB];
            genIntr[g]     = |gen[g].ris;
            adcTrig[g]     = gen[g].adcTrig;
        end
    end

    assign faultIntr = faultRis && faultIntEn;
    assign pwmPin    = pinReg;

    // ************************************************************
    // Next state of generators, registers and bus.
    // ************************************************************
    always_comb begin : nextState
        logic [5:0]  rel;
        logic [31:0] md;
        logic [3:0]  rawOut;
        logic        raw;
        logic        zeroHit;
        logic        gsel;
        rel = awAddr[5:0];
        md = merge(pwdb_pkg::RESET_VAL, wData, wStrb);
        rawOut = '0;
        raw = 1'b0;
        zeroHit = 1'b0;
        gsel = 1'b0;
        next_gen = gen;
        next_updateRequest = updateRequest;
        next_outputEnableMask = outputEnableMask;
        next_invertMask = invertMask;
        next_faultMask = faultMask;
        next_faultIntEn = faultIntEn;
        next_counterReset = '0;
        // fault sets status, stall never does
        next_faultRis = faultRis || faultIn;

        for (int g = 0; g < pwdb_pkg::NUM_GEN; g++) begin
            zeroHit = events[g][pwdb_pkg::EV_ZERO];
            if (zeroHit && gen[g].loadPend
                && (!gen[g].ctl[pwdb_pkg::GCTL_LOADSYNC] || updateRequest[g])) begin
                next_gen[g].periodValue = gen[g].loadShadow;
                next_gen[g].loadPend = 1'b0;
            end
            if (zeroHit && gen[g].cmpPend
                && (!gen[g].ctl[pwdb_pkg::GCTL_CMPSYNC] || updateRequest[g])) begin
                next_gen[g].compareFirst = gen[g].cmpAShadow;
                next_gen[g].compareSecond = gen[g].cmpBShadow;
                next_gen[g].cmpPend = 1'b0;
            end
            if (zeroHit && updateRequest[g]) begin
                next_updateRequest[g] = 1'b0;
            end
            if (counterReset[g]) begin
                next_gen[g].count = '0;
            end else if (running[g]) begin
                next_gen[g].count = (gen[g].count == '0) ? next_gen[g].periodValue
                                                          : gen[g].count - 1'b1;
            end
            next_gen[g].ris = gen[g].ris | (events[g] & gen[g].intSel);
            next_gen[g].adcTrig = |(events[g] & gen[g].trigSel);

            raw = genFirstRawOut[g];
            next_gen[g].prevRaw = raw;
            if (raw && !gen[g].prevRaw) begin
                next_gen[g].riseCnt = gen[g].dbRise;
            end else if (gen[g].riseCnt != '0) begin
                next_gen[g].riseCnt = gen[g].riseCnt - 1'b1;
            end
            if (!raw && gen[g].prevRaw) begin
                next_gen[g].fallCnt = gen[g].dbFall;
            end else if (gen[g].fallCnt != '0) begin
                next_gen[g].fallCnt = gen[g].fallCnt - 1'b1;
            end
            if (gen[g].dbEn) begin
                next_gen[g].dbFirst = raw && next_gen[g].riseCnt == '0;
                next_gen[g].dbSecond = !raw && next_gen[g].fallCnt == '0;
            end else begin
                next_gen[g].dbFirst = raw;
                next_gen[g].dbSecond = genSecondRawOut[g];
            end
            rawOut[2*g] = gen[g].dbFirst;
            rawOut[2*g+1] = gen[g].dbSecond;
        end

        for (int i = 0; i < pwdb_pkg::NUM_OUT; i++) begin
            next_pinReg[i] = (rawOut[i] && outputEnableMask[i] && !(faultIn && faultMask[i]))
                             ^ invertMask[i];
        end

        next_awAddr = awAddr;
        next_awHeld = awHeld;
        next_wData = wData;
        next_wStrb = wStrb;
        next_wHeld = wHeld;
        next_bValid = bValid && !s_axi_bready;
        next_bResp = bResp;
        if (s_axi_awvalid && s_axi_awready) begin
            next_awAddr = s_axi_awaddr;
            next_awHeld = 1'b1;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            next_wData = s_axi_wdata;
            next_wStrb = s_axi_wstrb;
            next_wHeld = 1'b1;
        end

        if (doWrite) begin
            next_awHeld = 1'b0;
            next_wHeld = 1'b0;
            next_bValid = 1'b1;
            next_bResp = isMapped(awAddr) ? pwdb_pkg::RESP_OKAY : pwdb_pkg::RESP_SLVERR;
            case (awAddr)
                pwdb_pkg::OFF_CTL: next_updateRequest = next_updateRequest | md[1:0];
                pwdb_pkg::OFF_SYNC: next_counterReset = md[1:0];
                pwdb_pkg::OFF_ENABLE: next_outputEnableMask = md[3:0];
                pwdb_pkg::OFF_INVERT: next_invertMask = md[3:0];
                pwdb_pkg::OFF_FAULT: next_faultMask = md[3:0];
                pwdb_pkg::OFF_INTEN: next_faultIntEn = md[pwdb_pkg::FAULT_POS];
                pwdb_pkg::OFF_ISC: begin
                    next_faultRis = faultIn || (faultRis && !md[pwdb_pkg::FAULT_POS]);
                end
                default: begin
                end
            endcase
            if (awAddr[11:8] == 4'h0 && (awAddr[7:6] == 2'h1 || awAddr[7:6] == 2'h2)) begin
                gsel = awAddr[7];
                case (rel)
                    pwdb_pkg::G_CTL: next_gen[gsel].ctl = md[3:0];
                    pwdb_pkg::G_INTEN: begin
                        next_gen[gsel].intSel = md[3:0];
                        next_gen[gsel].trigSel = md[pwdb_pkg::TRIG_POS +: 4];
                    end
                    pwdb_pkg::G_ISC: begin
                        next_gen[gsel].ris = (gen[gsel].ris & ~md[3:0])
                                           | (events[gsel] & gen[gsel].intSel);
                    end
                    pwdb_pkg::G_LOAD: begin
                        next_gen[gsel].loadShadow = md[pwdb_pkg::CNT_W-1:0];
                        next_gen[gsel].loadPend = 1'b1;
                    end
                    pwdb_pkg::G_CMPA: begin
                        next_gen[gsel].cmpAShadow = md[pwdb_pkg::CNT_W-1:0];
                        next_gen[gsel].cmpPend = 1'b1;
                    end
                    pwdb_pkg::G_CMPB: begin
                        next_gen[gsel].cmpBShadow = md[pwdb_pkg::CNT_W-1:0];
                        next_gen[gsel].cmpPend = 1'b1;
                    end
                    pwdb_pkg::G_DBCTL: next_gen[gsel].dbEn = md[0];
                    pwdb_pkg::G_DBRISE: next_gen[gsel].dbRise = md[pwdb_pkg::DB_W-1:0];
                    pwdb_pkg::G_DBFALL: next_gen[gsel].dbFall = md[pwdb_pkg::DB_W-1:0];
                    default: begin
                    end
                endcase
            end
        end
    end : nextState

    // ************************************************************
    // Read data.
    // ************************************************************
    always_comb begin : readNext
        logic [5:0]          r;
        pwdb_pkg::pwdb_gen_t s;
        r = s_axi_araddr[5:0];
        s = gen[s_axi_araddr[7]];
        next_rValid = rValid && !s_axi_rready;
        next_rResp = rResp;
        next_rData = rData;
        if (doRead) begin
            next_rValid = 1'b1;
            next_rResp = isMapped(s_axi_araddr) ? pwdb_pkg::RESP_OKAY : pwdb_pkg::RESP_SLVERR;
            next_rData = pwdb_pkg::RESET_VAL;
            case (s_axi_araddr)
                pwdb_pkg::OFF_CTL: next_rData[1:0] = updateRequest;
                pwdb_pkg::OFF_SYNC: next_rData[1:0] = counterReset;
                pwdb_pkg::OFF_ENABLE: next_rData[3:0] = outputEnableMask;
                pwdb_pkg::OFF_INVERT: next_rData[3:0] = invertMask;
                pwdb_pkg::OFF_FAULT: next_rData[3:0] = faultMask;
                pwdb_pkg::OFF_INTEN: next_rData[pwdb_pkg::FAULT_POS] = faultIntEn;
                pwdb_pkg::OFF_RIS: begin
                    next_rData[1:0] = genIntr;
                    next_rData[pwdb_pkg::FAULT_POS] = faultRis;
                end
                pwdb_pkg::OFF_ISC: begin
                    next_rData[1:0] = genIntr;
                    next_rData[pwdb_pkg::FAULT_POS] = faultIntr;
                end
                pwdb_pkg::OFF_STATUS: next_rData[0] = faultIn;
                default: begin
                end
            endcase
            if (s_axi_araddr[11:8] == 4'h0
                && (s_axi_araddr[7:6] == 2'h1 || s_axi_araddr[7:6] == 2'h2)) begin
                case (r)
                    pwdb_pkg::G_CTL: next_rData[3:0] = s.ctl;
                    pwdb_pkg::G_INTEN: begin
                        next_rData[3:0] = s.intSel;
                        next_rData[pwdb_pkg::TRIG_POS +: 4] = s.trigSel;
                    end
                    pwdb_pkg::G_RIS: next_rData[3:0] = s.ris;
                    pwdb_pkg::G_ISC: next_rData[3:0] = s.ris;
                    pwdb_pkg::G_LOAD: next_rData[pwdb_pkg::CNT_W-1:0] = s.loadShadow;
                    pwdb_pkg::G_COUNT: next_rData[pwdb_pkg::CNT_W-1:0] = s.count;
                    pwdb_pkg::G_CMPA: next_rData[pwdb_pkg::CNT_W-1:0] = s.cmpAShadow;
                    pwdb_pkg::G_CMPB: next_rData[pwdb_pkg::CNT_W-1:0] = s.cmpBShadow;
                    pwdb_pkg::G_DBCTL: next_rData[0] = s.dbEn;
                    pwdb_pkg::G_DBRISE: next_rData[pwdb_pkg::DB_W-1:0] = s.dbRise;
                    pwdb_pkg::G_DBFALL: next_rData[pwdb_pkg::DB_W-1:0] = s.dbFall;
                    default: begin
                    end
                endcase
            end
        end
    end : readNext

    // ************************************************************
    // State registers.
    // ************************************************************
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            for (int g = 0; g < pwdb_pkg::NUM_GEN; g++) begin
                gen[g] <= '0;
            end
            updateRequest <= '0;
            counterReset <= '0;
            outputEnableMask <= '0;
            invertMask <= '0;
            faultMask <= '0;
            faultIntEn <= 1'b0;
            faultRis <= 1'b0;
            pinReg <= '0;
            awAddr <= '0;
            awHeld <= 1'b0;
            wData <= '0;
            wStrb <= '0;
            wHeld <= 1'b0;
            bValid <= 1'b0;
            bResp <= '0;
            rValid <= 1'b0;
            rResp <= '0;
            rData <= '0;
        end else if (clkEn) begin
            gen <= next_gen;
            updateRequest <= next_updateRequest;
            counterReset <= next_counterReset;
            outputEnableMask <= next_outputEnableMask;
            invertMask <= next_invertMask;
            faultMask <= next_faultMask;
            faultIntEn <= next_faultIntEn;
            faultRis <= next_faultRis;
            pinReg <= next_pinReg;
            awAddr <= next_awAddr;
            awHeld <= next_awHeld;
            wData <= next_wData;
            wStrb <= next_wStrb;
            wHeld <= next_wHeld;
            bValid <= next_bValid;
            bResp <= next_bResp;
            rValid <= next_rValid;
            rResp <= next_rResp;
            rData <= next_rData;
        end
    end

endmodule : pwdb_top
